// *** core/spis_sequencer.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - Button powers support processor, diskette and I/O adapters first.
// - Run base self-tests; load support microcode only when all pass.
// - Test console adapters and power adapter; init power adapter if clean.
// - Fill control storage, read load program, test console path, then power.
// - In order: processor, channels, fitted channel adapter, remote devices.
// - Service mode toggles processor or channel adapter power on its own.
// - Init processor hardware at sequence end only if powering was clean.
// - Auto-load processor microcode after power-on only when option enabled.
// - Finally init local channel adapter and show general selection screen.
// - Diskette steered by embedded command bytes; no user path to drive.
// - Parity-check reloadable control storage while processor microcode is loaded.
// - Abort any microcode load when diskette and processor serials differ.
// - Temporary control storage patches are also written to the diskette.
// - Processor power-off clears processor control storage; support storage flag stays set.
// - At most four native devices; primary console with panel required.
// - Support bus adapter gives direct path to maintenance hardware.
// - Support bus adapter raises periodic power-monitoring tick.
// - Adapter drives system and wait lamps and serves lamp test.
module spis_sequencer (
  // Clock and reset
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          clk_en_in,
  // Operator panel
  input  wire logic                          power_on_btn_in,
  input  wire logic                          ce_mode_in,
  input  wire logic                          ce_ipf_toggle_in,
  input  wire logic                          ce_ctca_toggle_in,
  input  wire logic                          auto_iml_en_in,
  input  wire logic                          lamp_test_in,
  input  wire logic                          system_active_in,
  input  wire logic                          wait_state_in,
  // Configuration
  input  wire logic                          ctca_fitted_in,
  input  wire logic [spis_pkg::NATIVE_W-1:0] native_count_in,
  input  wire logic                          primary_console_in,
  input  wire logic [spis_pkg::SERIAL_W-1:0] proc_serial_in,
  input  wire logic [spis_pkg::SERIAL_W-1:0] disk_serial_in,
  input  wire logic                          power_good_in,
  // Step handshake with support microcode
  input  wire logic                          step_done_in,
  input  wire logic                          step_fail_in,
  input  wire logic                          iml_req_in,
  input  wire logic                          cs_parity_err_in,
  input  wire logic                          patch_req_in,
  input  wire logic                          patch_disk_done_in,
  // Maintenance path
  input  wire logic                          maint_req_in,
  output logic                               maint_grant_out,
  // Outputs
  output spis_pkg::spis_power_s              power_out,
  output spis_pkg::spis_task_s               task_out,
  output spis_pkg::spis_step_e               step_out,
  output spis_pkg::spis_err_e                err_out,
  output logic                               error_out,
  output logic                               ready_out,
  output logic                               selection_screen_out,
  output logic                               cs_valid_out,
  output logic                               patch_disk_write_out,
  output logic                               user_disk_allow_out,
  output logic                               pwr_mon_tick_out,
  output logic                               lamp_system_out,
  output logic                               lamp_wait_out
);

  spis_pkg::spis_state_s st_ff;
  spis_pkg::spis_state_s nxt_st;

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic spis_pkg::spis_task_s step_task(
    input spis_pkg::spis_step_e s
  );
    spis_pkg::spis_task_s t;
    t = '0;
    case (s)
      spis_pkg::SPIS_DIAG_BASE: t.diag_base = 1'b1;
      spis_pkg::SPIS_LOAD_SP:   t.load_sp   = 1'b1;
      spis_pkg::SPIS_DIAG_CONS: t.diag_cons = 1'b1;
      spis_pkg::SPIS_INIT_PCA:  t.init_pca  = 1'b1;
      spis_pkg::SPIS_FILL_CS:   t.fill_cs   = 1'b1;
      spis_pkg::SPIS_READ_PROG: t.read_prog = 1'b1;
      spis_pkg::SPIS_TEST_PATH: t.test_path = 1'b1;
      spis_pkg::SPIS_INIT_IPF:  t.init_ipf  = 1'b1;
      spis_pkg::SPIS_IML_IPF:   t.iml_ipf   = 1'b1;
      spis_pkg::SPIS_INIT_LCA:  t.init_lca  = 1'b1;
      default:                  t = '0;
    endcase
    return t;
  endfunction

  // Power steps complete on power good rather than a microcode handshake
  function automatic logic is_power_step(input spis_pkg::spis_step_e s);
    return (s == spis_pkg::SPIS_PWR_BASE) || (s == spis_pkg::SPIS_PWR_IPF) ||
           (s == spis_pkg::SPIS_PWR_CHAN) || (s == spis_pkg::SPIS_PWR_CTCA) ||
           (s == spis_pkg::SPIS_PWR_REM);
  endfunction

  function automatic logic serial_ok(
    input logic [spis_pkg::SERIAL_W-1:0] a,
    input logic [spis_pkg::SERIAL_W-1:0] b
  );
    return a == b;
  endfunction

  logic step_busy;
  logic step_ok;
  logic load_step;
  logic native_bad;
  logic tmo_hit;

  assign step_busy  = (st_ff.step != spis_pkg::SPIS_IDLE) &&
                      (st_ff.step != spis_pkg::SPIS_READY) &&
                      (st_ff.step != spis_pkg::SPIS_ERROR);
  assign step_ok    = is_power_step(st_ff.step) ? power_good_in
                                                : step_done_in;
  assign load_step  = (st_ff.step == spis_pkg::SPIS_LOAD_SP) ||
                      (st_ff.step == spis_pkg::SPIS_IML_IPF);
  assign native_bad = (native_count_in > spis_pkg::NATIVE_MAX) ||
                      !primary_console_in;
  assign tmo_hit    = (st_ff.tmo_cnt ==
                       spis_pkg::TMO_W'(spis_pkg::STEP_TIMEOUT));

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;

    if (st_ff.tick_cnt ==
        spis_pkg::TICK_W'(spis_pkg::TICK_CYCLES - 1)) begin
      nxt_st.tick_cnt = spis_pkg::TICK_ZERO;
      nxt_st.tick     = st_ff.pwr.sp;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
    end

    nxt_st.lamp_system = lamp_test_in || system_active_in;
    nxt_st.lamp_wait   = lamp_test_in || wait_state_in;

    nxt_st.tmo_cnt = step_busy ? st_ff.tmo_cnt + 1'b1 : spis_pkg::TMO_ZERO;

    case (st_ff.step)
      spis_pkg::SPIS_IDLE: begin
        if (power_on_btn_in) begin
          nxt_st.step            = spis_pkg::SPIS_PWR_BASE;
          nxt_st.err             = spis_pkg::SPIS_ERR_NONE;
          nxt_st.pwr.sp          = 1'b1;
          nxt_st.pwr.diskette    = 1'b1;
          nxt_st.pwr.io_adapters = 1'b1;
        end
      end
      spis_pkg::SPIS_READY: begin
        if (ce_mode_in && ce_ipf_toggle_in) begin
          nxt_st.pwr.ipf = !st_ff.pwr.ipf;
          // power off loses processor control storage
          if (st_ff.pwr.ipf) begin
            nxt_st.iml_done = 1'b0;
          end
        end
        if (ce_mode_in && ce_ctca_toggle_in && ctca_fitted_in) begin
          nxt_st.pwr.ctca = !st_ff.pwr.ctca;
        end
        if (iml_req_in && st_ff.pwr.ipf) begin
          nxt_st.step = spis_pkg::SPIS_IML_IPF;
        end
      end
      spis_pkg::SPIS_ERROR: begin
        if (power_on_btn_in) begin
          nxt_st.step = spis_pkg::SPIS_IDLE;
          nxt_st.iml_done = 1'b0;
        end
      end
      default: begin
        if (load_step && !serial_ok(disk_serial_in, proc_serial_in)) begin
          nxt_st.step = spis_pkg::SPIS_ERROR;
          nxt_st.err  = spis_pkg::SPIS_ERR_SERIAL;
        end else if (step_fail_in) begin
          nxt_st.step = spis_pkg::SPIS_ERROR;
          nxt_st.err  = is_power_step(st_ff.step) ?
                        spis_pkg::SPIS_ERR_POWER : spis_pkg::SPIS_ERR_TEST;
        end else if (tmo_hit) begin
          nxt_st.step = spis_pkg::SPIS_ERROR;
          nxt_st.err  = spis_pkg::SPIS_ERR_TMO;
        end else if (step_ok) begin
          nxt_st.tmo_cnt = spis_pkg::TMO_ZERO;
          case (st_ff.step)
            spis_pkg::SPIS_PWR_BASE:  nxt_st.step = spis_pkg::SPIS_DIAG_BASE;
            spis_pkg::SPIS_DIAG_BASE: nxt_st.step = spis_pkg::SPIS_LOAD_SP;
            spis_pkg::SPIS_LOAD_SP:   nxt_st.step = spis_pkg::SPIS_DIAG_CONS;
            // init power adapter only if clean
            spis_pkg::SPIS_DIAG_CONS: begin
              if (native_bad) begin
                nxt_st.step = spis_pkg::SPIS_ERROR;
                nxt_st.err  = spis_pkg::SPIS_ERR_CONFIG;
              end else begin
                nxt_st.step = spis_pkg::SPIS_INIT_PCA;
              end
            end
            spis_pkg::SPIS_INIT_PCA:  nxt_st.step = spis_pkg::SPIS_FILL_CS;
            spis_pkg::SPIS_FILL_CS: begin
              nxt_st.step     = spis_pkg::SPIS_READ_PROG;
              nxt_st.cs_valid = 1'b1;
            end
            spis_pkg::SPIS_READ_PROG: nxt_st.step = spis_pkg::SPIS_TEST_PATH;
            spis_pkg::SPIS_TEST_PATH: begin
              nxt_st.step    = spis_pkg::SPIS_PWR_IPF;
              nxt_st.pwr.ipf = 1'b1;
            end
            spis_pkg::SPIS_PWR_IPF: begin
              nxt_st.step         = spis_pkg::SPIS_PWR_CHAN;
              nxt_st.pwr.channels = 1'b1;
            end
            spis_pkg::SPIS_PWR_CHAN: begin
              if (ctca_fitted_in) begin
                nxt_st.step     = spis_pkg::SPIS_PWR_CTCA;
                nxt_st.pwr.ctca = 1'b1;
              end else begin
                nxt_st.step           = spis_pkg::SPIS_PWR_REM;
                nxt_st.pwr.remote_dev = 1'b1;
              end
            end
            spis_pkg::SPIS_PWR_CTCA: begin
              nxt_st.step           = spis_pkg::SPIS_PWR_REM;
              nxt_st.pwr.remote_dev = 1'b1;
            end
            spis_pkg::SPIS_PWR_REM:   nxt_st.step = spis_pkg::SPIS_INIT_IPF;
            spis_pkg::SPIS_INIT_IPF:  nxt_st.step = auto_iml_en_in ?
                                        spis_pkg::SPIS_IML_IPF :
                                        spis_pkg::SPIS_INIT_LCA;
            spis_pkg::SPIS_IML_IPF: begin
              nxt_st.iml_done = 1'b1;
              nxt_st.step     = st_ff.iml_done ? spis_pkg::SPIS_READY :
                                                 spis_pkg::SPIS_INIT_LCA;
            end
            spis_pkg::SPIS_INIT_LCA:  nxt_st.step = spis_pkg::SPIS_READY;
            default:                  nxt_st.step = spis_pkg::SPIS_ERROR;
          endcase
        end
      end
    endcase

    if (cs_parity_err_in && st_ff.iml_done &&
        st_ff.step != spis_pkg::SPIS_ERROR) begin
      nxt_st.step = spis_pkg::SPIS_ERROR;
      nxt_st.err  = spis_pkg::SPIS_ERR_PARITY;
    end

    if (patch_req_in && st_ff.step == spis_pkg::SPIS_READY) begin
      nxt_st.patch_busy = 1'b1;
    end else if (patch_disk_done_in) begin
      nxt_st.patch_busy = 1'b0;
    end
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else if (clk_en_in) begin
      st_ff <= nxt_st;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // native devices are never switched here
  assign power_out            = st_ff.pwr;
  assign task_out             = step_task(st_ff.step);
  assign step_out             = st_ff.step;
  assign err_out              = st_ff.err;
  assign error_out            = (st_ff.step == spis_pkg::SPIS_ERROR);
  assign ready_out            = (st_ff.step == spis_pkg::SPIS_READY);
  assign selection_screen_out = ready_out;
  assign cs_valid_out         = st_ff.cs_valid;
  assign patch_disk_write_out = st_ff.patch_busy;
  assign user_disk_allow_out  = 1'b0;
  assign maint_grant_out      = maint_req_in && st_ff.pwr.sp;
  assign pwr_mon_tick_out     = st_ff.tick;
  assign lamp_system_out      = st_ff.lamp_system;
  assign lamp_wait_out        = st_ff.lamp_wait;

endmodule

// *** inc/spis_pkg.sv ***
package spis_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned TICK_PERIOD_US = 1000;
  localparam int unsigned TICK_CYCLES    =
    (TICK_PERIOD_US * (CLK_HZ / 1_000_000));
  localparam int unsigned STEP_TIMEOUT   = 65535;

  // ********************************************************************
  // Sizes and constants
  // ********************************************************************
  localparam int unsigned TICK_W    = 20;
  localparam int unsigned TMO_W     = 16;
  localparam int unsigned SERIAL_W  = 24;
  localparam int unsigned NATIVE_W  = 3;
  localparam logic [2:0]  NATIVE_MAX = 3'h4;
  localparam logic [TICK_W-1:0] TICK_ZERO = 20'h0_0000;
  localparam logic [TMO_W-1:0]  TMO_ZERO  = 16'h0000;

  // ********************************************************************
  // Step and error codes
  // ********************************************************************
  typedef enum logic [4:0] {
    SPIS_IDLE      = 5'b00000,
    SPIS_PWR_BASE  = 5'b00001,
    SPIS_DIAG_BASE = 5'b00010,
    SPIS_LOAD_SP   = 5'b00011,
    SPIS_DIAG_CONS = 5'b00100,
    SPIS_INIT_PCA  = 5'b00101,
    SPIS_FILL_CS   = 5'b00110,
    SPIS_READ_PROG = 5'b00111,
    SPIS_TEST_PATH = 5'b01000,
    SPIS_PWR_IPF   = 5'b01001,
    SPIS_PWR_CHAN  = 5'b01010,
    SPIS_PWR_CTCA  = 5'b01011,
    SPIS_PWR_REM   = 5'b01100,
    SPIS_INIT_IPF  = 5'b01101,
    SPIS_IML_IPF   = 5'b01110,
    SPIS_INIT_LCA  = 5'b01111,
    SPIS_READY     = 5'b10000,
    SPIS_ERROR     = 5'b10001
  } spis_step_e;

  typedef enum logic [2:0] {
    SPIS_ERR_NONE   = 3'b000,
    SPIS_ERR_TEST   = 3'b001,
    SPIS_ERR_POWER  = 3'b010,
    SPIS_ERR_SERIAL = 3'b011,
    SPIS_ERR_PARITY = 3'b100,
    SPIS_ERR_TMO    = 3'b101,
    SPIS_ERR_CONFIG = 3'b110
  } spis_err_e;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic sp;
    logic diskette;
    logic io_adapters;
    logic ipf;
    logic channels;
    logic ctca;
    logic remote_dev;
  } spis_power_s;

  typedef struct packed {
    logic diag_base;
    logic load_sp;
    logic diag_cons;
    logic init_pca;
    logic fill_cs;
    logic read_prog;
    logic test_path;
    logic init_ipf;
    logic iml_ipf;
    logic init_lca;
  } spis_task_s;

  typedef struct packed {
    spis_step_e               step;
    spis_err_e                err;
    spis_power_s              pwr;
    logic                     cs_valid;
    logic                     iml_done;
    logic                     patch_busy;
    logic                     tick;
    logic [TICK_W-1:0]        tick_cnt;
    logic [TMO_W-1:0]         tmo_cnt;
    logic                     lamp_system;
    logic                     lamp_wait;
  } spis_state_s;

endpackage

// *** bench/spis_sequencer_assertions.sv ***
`timescale 1ns/1ps

module spis_sequencer_assertions (
  // Clock and inputs
  input wire logic                          sys_clk_in,
  input wire logic                          rst_in,
  input wire logic                          clk_en_in,
  input wire logic                          power_on_btn_in,
  input wire logic                          lamp_test_in,
  input wire logic                          maint_req_in,
  input wire logic                          cs_parity_err_in,
  input wire logic [spis_pkg::SERIAL_W-1:0] proc_serial_in,
  input wire logic [spis_pkg::SERIAL_W-1:0] disk_serial_in,
  // Outputs watched
  input wire spis_pkg::spis_power_s         power_out,
  input wire spis_pkg::spis_step_e          step_out,
  input wire spis_pkg::spis_err_e           err_out,
  input wire logic                          maint_grant_out,
  input wire logic                          user_disk_allow_out,
  input wire logic                          pwr_mon_tick_out,
  input wire logic                          lamp_system_out,
  input wire logic                          lamp_wait_out
);
  localparam int TICK_LAST = spis_pkg::TICK_CYCLES - 1;

  logic [spis_pkg::TICK_W-1:0] tick_gap_ff;
  logic                        tick_seen_ff;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // ******************************************************************
  // Tick spacing helper
  // ******************************************************************
  // First tick after power-up has no reference, so it is not judged
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !power_out.sp) begin
      tick_gap_ff  <= '0;
      tick_seen_ff <= 1'h0;
    end else if (clk_en_in) begin
      tick_gap_ff  <= pwr_mon_tick_out ? '0 : tick_gap_ff + 1'h1;
      tick_seen_ff <= tick_seen_ff | pwr_mon_tick_out;
    end
  end

  sequence base_on_s;
    step_out == spis_pkg::SPIS_PWR_BASE && power_out.sp &&
    power_out.diskette && power_out.io_adapters;
  endsequence

  sequence serial_abort_s;
    step_out == spis_pkg::SPIS_ERROR &&
    err_out == spis_pkg::SPIS_ERR_SERIAL;
  endsequence

  start_power_a: assert property (
    step_out == spis_pkg::SPIS_IDLE && power_on_btn_in && clk_en_in
    |=> base_on_s) else $error("base power not applied");
  load_gate_a: assert property (
    $changed(step_out) && step_out == spis_pkg::SPIS_LOAD_SP
    |-> $past(step_out) == spis_pkg::SPIS_DIAG_BASE)
    else $error("load entered without base tests");
  chan_order_a: assert property (
    $rose(power_out.channels) |-> power_out.ipf &&
    $past(step_out) == spis_pkg::SPIS_PWR_IPF)
    else $error("channels powered out of order");
  remote_order_a: assert property (
    $rose(power_out.remote_dev) |-> power_out.ipf && power_out.channels)
    else $error("remote devices powered early");
  serial_check_a: assert property (
    step_out inside {spis_pkg::SPIS_LOAD_SP, spis_pkg::SPIS_IML_IPF} &&
    clk_en_in && !cs_parity_err_in && proc_serial_in != disk_serial_in
    |=> serial_abort_s) else $error("serial mismatch not aborted");
  tick_period_a: assert property (
    pwr_mon_tick_out && clk_en_in && tick_seen_ff
    |-> tick_gap_ff == TICK_LAST) else $error("tick spacing wrong");
  lamp_test_a: assert property (
    lamp_test_in && clk_en_in |=> lamp_system_out && lamp_wait_out)
    else $error("lamp test not lighting lamps");
  maint_path_a: assert property (
    maint_grant_out == (maint_req_in && power_out.sp))
    else $error("maintenance grant wrong");
  no_user_disk_a: assert property (
    user_disk_allow_out == 1'h0) else $error("user diskette access open");
endmodule

bind spis_sequencer spis_sequencer_assertions u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
  .power_on_btn_in(power_on_btn_in), .lamp_test_in(lamp_test_in),
  .maint_req_in(maint_req_in), .cs_parity_err_in(cs_parity_err_in),
  .proc_serial_in(proc_serial_in), .disk_serial_in(disk_serial_in),
  .power_out(power_out), .step_out(step_out), .err_out(err_out),
  .maint_grant_out(maint_grant_out), .lamp_wait_out(lamp_wait_out),
  .user_disk_allow_out(user_disk_allow_out),
  .pwr_mon_tick_out(pwr_mon_tick_out), .lamp_system_out(lamp_system_out));

// *** bench/spis_far_model.sv ***
`timescale 1ns/1ps

module spis_far_model (
  // Clock and sequencer view
  input  wire logic                 sys_clk_in,
  input  wire spis_pkg::spis_step_e step_in,
  // Bench control
  input  wire spis_pkg::spis_step_e fail_step_in,
  input  wire logic [3:0]           delay_in,
  // Answers
  output logic                      step_done_out,
  output logic                      step_fail_out,
  output logic                      power_good_out
);
  spis_pkg::spis_step_e last_step;
  int                   cnt;
  logic                 pwr_step, busy, go, hit;

  always_comb begin
    pwr_step = step_in inside {spis_pkg::SPIS_PWR_BASE,
      spis_pkg::SPIS_PWR_IPF, spis_pkg::SPIS_PWR_CHAN,
      spis_pkg::SPIS_PWR_CTCA, spis_pkg::SPIS_PWR_REM};
    busy = !(step_in inside {spis_pkg::SPIS_IDLE, spis_pkg::SPIS_READY,
      spis_pkg::SPIS_ERROR});
  end

  initial begin
    {step_done_out, step_fail_out, power_good_out} = 3'h0;
    cnt = 0;
    last_step = spis_pkg::SPIS_IDLE;
  end

  // Only units the sequencer switched ever report power good
  always @(negedge sys_clk_in) begin
    cnt = (step_in == last_step) ? cnt + 1 : 0;
    last_step = step_in;
    // Repeat answers so a frozen sequencer still sees one later
    go = busy && cnt >= delay_in && ((cnt - delay_in) % 2 == 0);
    hit = busy && step_in == fail_step_in;
    power_good_out <= pwr_step && cnt >= delay_in && !hit;
    step_done_out  <= go && !pwr_step && !hit;
    step_fail_out  <= go && hit;
  end
endmodule

// *** bench/spis_sequencer_bench.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  fails++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end

module spis_sequencer_bench;
  logic sys_clk_in, rst_in, clk_en_in, power_on_btn_in, ce_mode_in;
  logic ce_ipf_toggle_in, ce_ctca_toggle_in, auto_iml_en_in, lamp_test_in;
  logic system_active_in, wait_state_in, ctca_fitted_in, primary_console_in;
  logic power_good_in, step_done_in, step_fail_in, iml_req_in;
  logic cs_parity_err_in, patch_req_in, patch_disk_done_in, maint_req_in;
  logic maint_grant_out, error_out, ready_out, selection_screen_out;
  logic cs_valid_out, patch_disk_write_out, user_disk_allow_out;
  logic pwr_mon_tick_out, lamp_system_out, lamp_wait_out;
  logic [spis_pkg::NATIVE_W-1:0] native_count_in;
  logic [spis_pkg::SERIAL_W-1:0] proc_serial_in, disk_serial_in;
  spis_pkg::spis_power_s         power_out;
  spis_pkg::spis_step_e          step_out, fail_step;
  spis_pkg::spis_err_e           err_out;
  logic [3:0]                    delay;
  logic [31:0]                   seen;
  int                            fails, num_checks;

  spis_sequencer u_dut (.sys_clk_in, .rst_in, .clk_en_in, .power_on_btn_in,
    .ce_mode_in, .ce_ipf_toggle_in, .ce_ctca_toggle_in, .auto_iml_en_in,
    .lamp_test_in, .system_active_in, .wait_state_in, .ctca_fitted_in,
    .native_count_in, .primary_console_in, .proc_serial_in,
    .disk_serial_in, .power_good_in, .step_done_in, .step_fail_in,
    .iml_req_in, .cs_parity_err_in, .patch_req_in, .patch_disk_done_in,
    .maint_req_in, .maint_grant_out, .power_out, .task_out(), .step_out,
    .err_out, .error_out, .ready_out, .selection_screen_out, .cs_valid_out,
    .patch_disk_write_out, .user_disk_allow_out, .pwr_mon_tick_out,
    .lamp_system_out, .lamp_wait_out);

  spis_far_model u_far (.sys_clk_in, .step_in(step_out),
    .fail_step_in(fail_step), .delay_in(delay),
    .step_done_out(step_done_in), .step_fail_out(step_fail_in),
    .power_good_out(power_good_in));

  initial begin
    sys_clk_in = 1'h0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) seen[step_out] <= 1'h1;

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  task automatic pulse(ref logic s);
    @(negedge sys_clk_in);
    s = 1'h1;
    @(negedge sys_clk_in);
    s = 1'h0;
    cyc(2);
  endtask

  // Bounded wait; running out ends the run
  task automatic wait_step(input spis_pkg::spis_step_e s);
    for (int i = 0; i < 500 && step_out !== s; i++) cyc(1);
    `CHK("step", s, step_out)
    if (step_out !== s) complete_run();
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset();
    cyc(1);
    rst_in = 1'h1;
    cyc(20);
    rst_in = 1'h0;
    `CHK("power", 7'h00, power_out)
    `CHK("cs_valid", 1'h0, cs_valid_out)
    clk_en_in = 1'h0;
    pulse(power_on_btn_in);
    clk_en_in = 1'h1;
    cyc(2);
    `CHK("frozen", spis_pkg::SPIS_IDLE, step_out)
    $display("test reset done");
  endtask

  task automatic t_boot(input logic a, input logic c, input logic [3:0] d);
    auto_iml_en_in = a;
    ctca_fitted_in = c;
    delay = d;
    seen = '0;
    pulse(power_on_btn_in);
    wait_step(spis_pkg::SPIS_READY);
    `CHK("ipf", 1'h1, power_out.ipf)
    `CHK("remote", 1'h1, power_out.remote_dev)
    `CHK("ctca", c, power_out.ctca)
    `CHK("ctca_step", c, seen[spis_pkg::SPIS_PWR_CTCA])
    `CHK("auto_load", a, seen[spis_pkg::SPIS_IML_IPF])
    `CHK("pca_init", 1'h1, seen[spis_pkg::SPIS_INIT_PCA])
    `CHK("path_test", 1'h1, seen[spis_pkg::SPIS_TEST_PATH])
    `CHK("screen", 1'h1, selection_screen_out)
    `CHK("error", 1'h0, error_out)
    $display("test boot done");
  endtask

  task automatic t_ready();
    int n = 0;
    repeat (20000) begin
      cyc(1);
      n += pwr_mon_tick_out;
    end
    `CHK("ticks", 2, n)
    pulse(ce_ipf_toggle_in);
    `CHK("ipf_locked", 1'h1, power_out.ipf)
    ce_mode_in = 1'h1;
    pulse(ce_ipf_toggle_in);
    pulse(ce_ctca_toggle_in);
    `CHK("ipf_off", 1'h0, power_out.ipf)
    `CHK("ctca_off", 1'h0, power_out.ctca)
    `CHK("chan_kept", 1'h1, power_out.channels)
    pulse(ce_ipf_toggle_in);
    `CHK("ipf_on", 1'h1, power_out.ipf)
    seen = '0;
    pulse(iml_req_in);
    wait_step(spis_pkg::SPIS_READY);
    `CHK("manual_load", 1'h1, seen[spis_pkg::SPIS_IML_IPF])
    {system_active_in, maint_req_in} = 2'h3;
    cyc(2);
    `CHK("lamp_sys", 1'h1, lamp_system_out)
    `CHK("lamp_wait", 1'h0, lamp_wait_out)
    `CHK("grant", 1'h1, maint_grant_out)
    pulse(lamp_test_in);
    pulse(patch_req_in);
    `CHK("patch_wr", 1'h1, patch_disk_write_out)
    pulse(patch_disk_done_in);
    `CHK("patch_end", 1'h0, patch_disk_write_out)
    pulse(cs_parity_err_in);
    `CHK("parity", spis_pkg::SPIS_ERR_PARITY, err_out)
    pulse(power_on_btn_in);
    $display("test ready done");
  endtask

  task automatic t_refuse(input spis_pkg::spis_step_e s, input logic [2:0] nc,
    input logic pc, input logic bad, input spis_pkg::spis_err_e e);
    fail_step = s;
    native_count_in = nc;
    primary_console_in = pc;
    disk_serial_in = bad ? ~proc_serial_in : proc_serial_in;
    seen = '0;
    pulse(power_on_btn_in);
    wait_step(spis_pkg::SPIS_ERROR);
    `CHK("err", e, err_out)
    `CHK("flag", 1'h1, error_out)
    `CHK("no_init", 1'h0, seen[spis_pkg::SPIS_INIT_IPF])
    `CHK("no_load", s != spis_pkg::SPIS_DIAG_BASE,
      seen[spis_pkg::SPIS_LOAD_SP])
    {native_count_in, primary_console_in} = 4'h9;
    disk_serial_in = proc_serial_in;
    pulse(power_on_btn_in);
    `CHK("idle", spis_pkg::SPIS_IDLE, step_out)
    $display("test refuse done");
  endtask

  initial begin
    {power_on_btn_in, ce_mode_in, ce_ipf_toggle_in, ce_ctca_toggle_in,
      auto_iml_en_in, lamp_test_in, system_active_in, wait_state_in,
      ctca_fitted_in, iml_req_in, cs_parity_err_in, patch_req_in,
      patch_disk_done_in, maint_req_in, delay, seen, fails, num_checks} = '0;
    fail_step = spis_pkg::SPIS_IDLE;
    {native_count_in, primary_console_in} = 4'h9;
    {rst_in, clk_en_in} = 2'h3;
    proc_serial_in = 24'h5a_3c96;
    disk_serial_in = 24'h5a_3c96;
    cyc(20);
    rst_in = 1'h0;
    t_reset();
    t_boot(1'h0, 1'h0, 4'h0);
    t_reset();
    t_boot(1'h1, 1'h1, 4'h3);
    t_ready();
    t_refuse(spis_pkg::SPIS_DIAG_BASE, 3'h4, 1'h1, 1'h0,
      spis_pkg::SPIS_ERR_TEST);
    t_refuse(spis_pkg::SPIS_PWR_CHAN, 3'h4, 1'h1, 1'h0,
      spis_pkg::SPIS_ERR_POWER);
    t_refuse(spis_pkg::SPIS_IDLE, 3'h5, 1'h1, 1'h0,
      spis_pkg::SPIS_ERR_CONFIG);
    t_refuse(spis_pkg::SPIS_IDLE, 3'h4, 1'h0, 1'h0,
      spis_pkg::SPIS_ERR_CONFIG);
    t_refuse(spis_pkg::SPIS_IDLE, 3'h4, 1'h1, 1'h1,
      spis_pkg::SPIS_ERR_SERIAL);
    complete_run();
  end
endmodule
